/* File: mdsp_pkg.sv */
// Functional notes
// - command word: 16 bits, 6-bit address, data byte
// - reply: status byte then register data byte
// - deselected: ignore clock/data, output released
// - sample on falling, shift out on rising
// - most significant bit first both ways
// - not 16 clocks: framing error, word dropped
// - write returns register's previous value
// - power-up and sleep restore register defaults
// - layout: rw 15, address 14:9, parity 8
// - rw flag zero writes, one reads
// - whole word must have even parity
// - read returns addressed register contents
// - early select release latches clock framing fault
// - address above 0xC latches address fault
// - summary bit 3 low after power-on reset
// - summary bit 5: any serial fault
// - summary bit 1: thermal warning or shutdown
// - summary bit 0: any device fault
// - summary bit 6: buck regulator fault
// - summary bit 2 overvoltage, bit 4 overcurrent
// - short sleep pulse clears faults, keeps settings
// - sleep disables the serial port
// - parity failure sets second status bit 2
//
// constants shared by the serial status port modules
// assumes a 50 MHz system clock
package mdsp_pkg;
  // ********************
  // timing
  // ********************
  localparam int CLK_NS = 20;
  localparam int T_SLEEP_NS = 100000; // low time that means sleep
  localparam int SLEEP_CYC = (T_SLEEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLP_W = 24;
  // ********************
  // word layout
  // ********************
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 6;
  localparam int RW_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 9;
  localparam logic CMD_WRITE = 1'b0;
  localparam logic [4:0] RX_FULL = 5'h10;
  localparam logic [4:0] ADDR_READY = 5'h07;
  localparam logic [4:0] CNT_SAT = 5'h11;
  localparam logic [3:0] TOP_IDX = 4'hF;
  // ********************
  // register map
  // ********************
  localparam logic [5:0] ADDR_IC = 6'h00;
  localparam logic [5:0] ADDR_ST1 = 6'h01;
  localparam logic [5:0] ADDR_ST2 = 6'h02;
  localparam logic [5:0] ADDR_CTRL_LO = 6'h03;
  localparam logic [5:0] ADDR_MAX = 6'h0C;
  localparam int CTRL_N = 10;
  localparam logic [5:0] ADDR_CLR = 6'h03;
  localparam logic [7:0] CLR_MASK = 8'h01;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  // summary register bits
  localparam int IC_FAULT = 0;
  localparam int IC_THERM = 1;
  localparam int IC_OVERV = 2;
  localparam int IC_POR_ABSENT = 3;
  localparam int IC_OVERC = 4;
  localparam int IC_SPI = 5;
  localparam int IC_BUCK = 6;
  // second status register bits
  localparam int ST2_ADDR = 0;
  localparam int ST2_SCLK = 1;
  localparam int ST2_PAR = 2;
  localparam int ST2_HW_LO = 3;
  localparam int ST2_HW_HI = 6;
endpackage : mdsp_pkg

/* File: mdsp_frame_if.sv */
// frame signals between the serial engine and the register core
// assumes both ends run on the system clock
`timescale 1ns/10ps
`default_nettype none
interface mdsp_frame_if;
  import mdsp_pkg::*;
  logic [7:0] status_byte;
  logic [7:0] rd_data;
  logic [5:0] rx_addr;
  logic [4:0] bit_cnt;
  logic [15:0] rx_word;
  logic start;
  logic done;
  modport engine(input status_byte, rd_data,
    output rx_addr, bit_cnt, rx_word, start, done);
  modport core(output status_byte, rd_data,
    input rx_addr, bit_cnt, rx_word, start, done);
endinterface : mdsp_frame_if
`default_nettype wire

/* File: mdsp_sync.sv */
// two-stage synchroniser for pins from outside the clock domain
// assumes inputs are asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module mdsp_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  // first stage feeds only the second
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule : mdsp_sync
`default_nettype wire

/* File: mdsp_shift.sv */
// serial engine: bit counter, receive and transmit shifters
// assumes synchronised pin levels on the system clock
`timescale 1ns/10ps
`default_nettype none
module mdsp_shift import mdsp_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  input wire logic awake_in,
  mdsp_frame_if.engine fr,
  output logic sdo_out,
  output logic sdo_oe_out
);
  logic sclk_d_r, act_d_r;
  logic [4:0] cnt_r;
  logic [15:0] rx_r;
  logic [7:0] stat_r, data_r;
  // ********************
  // edge detection
  // ********************
  // deselected or asleep: clock edges are not seen
  wire active = !cs_n_in && awake_in;
  wire start = active && !act_d_r;
  wire stop = !active && act_d_r;
  wire fall = active && sclk_d_r && !sclk_in;
  wire rise = active && !sclk_d_r && sclk_in;
  wire [15:0] tx_w = {stat_r, data_r};
  wire [3:0] tx_idx = TOP_IDX - cnt_r[3:0];
  // ********************
  // shifters
  // ********************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_d_r <= 1'b0;
      act_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_in;
      act_d_r <= active;
    end
  end
  // counter saturates so long frames stay flagged
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= '0;
    end else if (fall && cnt_r != CNT_SAT) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_r <= '0;
    end else if (fall) begin
      rx_r <= {rx_r[14:0], sdi_in};
    end
  end
  // status latched at select, data once the address is in
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_r <= STAT_RST;
      data_r <= STAT_RST;
    end else if (start) begin
      stat_r <= fr.status_byte;
    end else if (cnt_r == ADDR_READY) begin
      data_r <= fr.rd_data;
    end
  end
  // first bit appears at select, the rest move on rising edges
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sdo_out <= 1'b0;
    end else if (start) begin
      sdo_out <= fr.status_byte[7];
    end else if (rise && cnt_r != '0 && cnt_r < RX_FULL) begin
      sdo_out <= tx_w[tx_idx];
    end
  end
  assign sdo_oe_out = act_d_r;
  assign fr.rx_addr = rx_r[ADDR_W-1:0];
  assign fr.bit_cnt = cnt_r;
  assign fr.rx_word = rx_r;
  assign fr.start = start;
  assign fr.done = stop;
  // ********************
  // checks
  // ********************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  chk_capture_fall: assert property (fall |=> rx_r[0] == $past(sdi_in))
    else $error("bit not captured on falling edge");
  chk_status_load: assert property (start |=> stat_r == $past(fr.status_byte))
    else $error("status byte not loaded at frame start");
endmodule : mdsp_shift
`default_nettype wire

/* File: mdsp_port.sv */
// top of the serial configuration and status port
// assumes fault sources are levels on the system clock;
// frame select, serial clock, data and sleep pins are asynchronous
`timescale 1ns/10ps
`default_nettype none
module mdsp_port import mdsp_pkg::*; #(
  parameter int SLEEP_CYCLES = SLEEP_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic frame_select_n_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  input wire logic sleep_control_n_in,
  input wire logic [7:0] bridge_status_in,
  input wire logic [3:0] supply_status_in,
  input wire logic overcurrent_in,
  input wire logic overvoltage_in,
  input wire logic thermal_warn_in,
  input wire logic thermal_shut_in,
  input wire logic buck_fault_in,
  input wire logic vm_por_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic asleep_out,
  output logic clear_faults_out,
  output logic [CTRL_N*8-1:0] ctrl_flat_out
);
  typedef enum logic [1:0] {SL_AWAKE, SL_PULSE, SL_ASLEEP} mdsp_sleep_e;

  // ********************
  // pin synchronisers
  // ********************
  // select and sleep enter inverted so the synchroniser's reset value is
  // their idle level; otherwise the first edges after reset would look
  // like a cut frame and a short sleep pulse
  logic sclk_s, sel_s, sdi_s, sleep_req_s;
  wire cs_n_s = !sel_s;
  wire slp_s = !sleep_req_s;
  mdsp_sync #(
    .W(4)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .d_in({sclk_in, !frame_select_n_in, sdi_in, !sleep_control_n_in}),
    .q_out({sclk_s, sel_s, sdi_s, sleep_req_s})
  );

  // ********************
  // sleep pin handling
  // ********************
  mdsp_sleep_e sl_state_r, sl_state_nxt;
  logic [SLP_W-1:0] low_cnt_r;
  wire slp_limit = low_cnt_r == SLP_W'(SLEEP_CYCLES - 1);
  // a short low pulse is a fault clear, a long one is sleep
  wire pulse_clear = sl_state_r == SL_PULSE && slp_s;
  wire asleep = sl_state_r == SL_ASLEEP;
  wire awake = !asleep;

  always_comb begin
    sl_state_nxt = sl_state_r;
    unique case (sl_state_r)
      SL_AWAKE: begin
        if (!slp_s) begin
          sl_state_nxt = SL_PULSE;
        end
      end
      SL_PULSE: begin
        if (slp_s) begin
          sl_state_nxt = SL_AWAKE;
        end else if (slp_limit) begin
          sl_state_nxt = SL_ASLEEP;
        end
      end
      SL_ASLEEP: begin
        if (slp_s) begin
          sl_state_nxt = SL_AWAKE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sl_state_r <= SL_AWAKE;
    end else begin
      sl_state_r <= sl_state_nxt;
    end
  end

  // low-time counter restarts each time the pin falls
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_cnt_r <= '0;
    end else if (sl_state_r != SL_PULSE) begin
      low_cnt_r <= '0;
    end else if (!slp_limit) begin
      low_cnt_r <= low_cnt_r + SLP_W'(1);
    end
  end

  // ********************
  // serial engine
  // ********************
  mdsp_frame_if fr ();
  mdsp_shift u_shift (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .sclk_in(sclk_s),
    .cs_n_in(cs_n_s),
    .sdi_in(sdi_s),
    .awake_in(awake),
    .fr(fr),
    .sdo_out(sdo_out),
    .sdo_oe_out(sdo_oe_out)
  );

  // ********************
  // frame checking
  // ********************
  wire [5:0] w_addr = fr.rx_word[ADDR_HI:ADDR_LO];
  wire [7:0] w_data = fr.rx_word[BYTE_W-1:0];
  wire w_rw = fr.rx_word[RW_BIT];
  // wrong clock count makes every other check moot
  wire frm_err = fr.done && fr.bit_cnt != RX_FULL;
  // odd count of ones over all sixteen bits is a failure
  wire par_err = fr.done && !frm_err && ^fr.rx_word;
  wire adr_err = fr.done && !frm_err && !par_err
    && w_addr > ADDR_MAX;
  wire frame_ok = fr.done && !frm_err && !par_err && !adr_err;
  wire is_ctrl = w_addr >= ADDR_CTRL_LO && w_addr <= ADDR_MAX;
  // status registers are read-only, writes to them are dropped
  wire wr_ok = frame_ok && w_rw == CMD_WRITE && is_ctrl;
  wire clr_cmd = wr_ok && w_addr == ADDR_CLR
    && (w_data & CLR_MASK) != 8'h00;
  wire clear = clr_cmd || pulse_clear;
  wire [3:0] wr_idx = 4'(w_addr - ADDR_CTRL_LO);
  // the clear bit never stays set, it is a command
  wire [7:0] wr_val = (w_addr == ADDR_CLR) ? (w_data & ~CLR_MASK)
    : w_data;

  // ********************
  // latched link faults
  // ********************
  logic sclk_flt_r, adr_flt_r, par_flt_r, por_absent_r;
  // a new fault in the clearing cycle still latches
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_flt_r <= 1'b0;
      adr_flt_r <= 1'b0;
      par_flt_r <= 1'b0;
    end else if (asleep) begin
      sclk_flt_r <= 1'b0;
      adr_flt_r <= 1'b0;
      par_flt_r <= 1'b0;
    end else begin
      sclk_flt_r <= frm_err || (sclk_flt_r && !clear);
      adr_flt_r <= adr_err || (adr_flt_r && !clear);
      par_flt_r <= par_err || (par_flt_r && !clear);
    end
  end

  // power-on flag reads low until a clear command or a short sleep pulse clears faults
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      por_absent_r <= 1'b0;
    end else if (asleep || vm_por_in) begin
      por_absent_r <= 1'b0;
    end else if (clear) begin
      por_absent_r <= 1'b1;
    end
  end

  // ********************
  // control registers
  // ********************
  logic [7:0] ctrl_r [CTRL_N];
  // old value reaches the reply before the write lands at frame end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < CTRL_N; i++) begin
        ctrl_r[i] <= CTRL_RST;
      end
    end else if (asleep) begin
      for (int i = 0; i < CTRL_N; i++) begin
        ctrl_r[i] <= CTRL_RST;
      end
    end else if (wr_ok) begin
      ctrl_r[wr_idx] <= wr_val;
    end
  end

  always_comb begin
    for (int i = 0; i < CTRL_N; i++) begin
      ctrl_flat_out[i*8 +: 8] = ctrl_r[i];
    end
  end

  // ********************
  // status registers
  // ********************
  wire link_flt = sclk_flt_r || adr_flt_r || par_flt_r;
  wire therm_flt = thermal_warn_in || thermal_shut_in;
  wire any_flt = link_flt || therm_flt || overvoltage_in || overcurrent_in
    || buck_fault_in || (|bridge_status_in)
    || (|supply_status_in);
  wire [7:0] ic_stat = {1'b0, buck_fault_in, link_flt, overcurrent_in,
    por_absent_r, overvoltage_in, therm_flt, any_flt};
  wire [7:0] st2_stat = {1'b0, supply_status_in, par_flt_r, sclk_flt_r,
    adr_flt_r};
  wire [5:0] rd_addr = fr.rx_addr;
  wire rd_ctrl = rd_addr >= ADDR_CTRL_LO && rd_addr <= ADDR_MAX;
  wire [3:0] rd_idx = 4'(rd_addr - ADDR_CTRL_LO);
  // unknown addresses answer zero
  wire [7:0] rd_ctl_val = rd_ctrl ? ctrl_r[rd_idx] : 8'h00;
  wire [7:0] rd_val = (rd_addr == ADDR_IC) ? ic_stat
    : (rd_addr == ADDR_ST1) ? bridge_status_in
    : (rd_addr == ADDR_ST2) ? st2_stat
    : rd_ctl_val;

  assign fr.status_byte = ic_stat;
  assign fr.rd_data = rd_val;
  assign asleep_out = asleep;
  assign clear_faults_out = clear;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // the pin was still low, then rises before the sleep limit
  sequence s_short_low;
    sl_state_r == SL_PULSE && !slp_s ##1 pulse_clear;
  endsequence

  // sleep wipes the flags, so a frame cut by sleep entry is excluded
  sequence s_bad_count;
    fr.done && fr.bit_cnt != RX_FULL && !asleep;
  endsequence

  sequence s_good_write;
    fr.done && fr.bit_cnt == RX_FULL && !(^fr.rx_word)
      && w_addr >= ADDR_CTRL_LO && w_addr <= ADDR_MAX
      && w_addr != ADDR_CLR && w_rw == CMD_WRITE;
  endsequence

  chk_idle_release: assert property (
    (cs_n_s || asleep) ##1 (cs_n_s || asleep) |=> !sdo_oe_out)
    else $error("serial output driven while deselected");

  chk_frame_fault: assert property (s_bad_count |=> sclk_flt_r)
    else $error("framing fault not latched");

  chk_bad_no_write: assert property (
    s_bad_count |=> $stable(ctrl_flat_out))
    else $error("malformed frame changed a register");

  chk_parity_flag: assert property (
    fr.done && fr.bit_cnt == RX_FULL && ^fr.rx_word
      |=> par_flt_r && $stable(ctrl_flat_out))
    else $error("parity error not flagged or word used");

  chk_addr_flag: assert property (
    fr.done && fr.bit_cnt == RX_FULL && !(^fr.rx_word)
      && w_addr > ADDR_MAX |=> adr_flt_r ##0 ic_stat[IC_SPI])
    else $error("address fault not latched");

  chk_write_lands: assert property (
    s_good_write |=> ctrl_r[$past(wr_idx)] == $past(w_data))
    else $error("write data not stored");

  chk_sleep_defaults: assert property (
    asleep |=> ctrl_flat_out == '0 && !link_flt && !por_absent_r)
    else $error("sleep did not restore defaults");

  // a good write or a supply reset in the clearing cycle is legal
  chk_pulse_clears: assert property (
    s_short_low ##0 !frm_err && !par_err && !adr_err && !wr_ok
      && !vm_por_in
      |=> !link_flt && por_absent_r && $stable(ctrl_flat_out))
    else $error("short sleep pulse did not clear faults");

  chk_por_flag: assert property (vm_por_in |=> !ic_stat[IC_POR_ABSENT])
    else $error("power-on flag not shown");

  chk_summary_bits: assert property (
    $rose(link_flt) |-> ic_stat[IC_SPI] && ic_stat[IC_FAULT])
    else $error("summary bits miss a serial fault");

endmodule : mdsp_port
`default_nettype wire

/* File: mdsp_ctrl_model.sv */
// serial controller model that drives the status port's link pins
// assumes the bench shows a released data-out line as its inverse
`timescale 1ns/10ps
`default_nettype none
module mdsp_ctrl_model #(
  parameter int HALF_NS = 80
) (
  output logic frame_select_n_out,
  output logic sclk_out,
  output logic sdi_out,
  input wire logic sdo_line_in
);
  // ********************
  // idle pins
  // ********************
  // clock parked low so both select edges see it low
  initial begin
    frame_select_n_out = 1'h1;
    sclk_out = 1'h0;
    sdi_out = 1'h0;
  end
  // ********************
  // one frame
  // ********************
  // nbits other than 16 breaks framing on purpose; reply is sampled
  // just before the next rise, since the port answers some cycles late
  task automatic xfer(input logic [15:0] word, input int nbits,
    output logic [15:0] rx);
    rx = 16'h0000;
    frame_select_n_out = 1'h0;
    #(2*HALF_NS);
    for (int i = 0; i < nbits; i++) begin
      sclk_out = 1'h1;
      sdi_out = (i < 16) ? word[15-i] : 1'h0;
      #(HALF_NS);
      sclk_out = 1'h0;
      #(HALF_NS-1);
      rx = {rx[14:0], sdo_line_in};
      #1;
    end
    frame_select_n_out = 1'h1;
    sdi_out = ~sdi_out; // a released line shows no stale level
    #480;
  endtask : xfer
endmodule : mdsp_ctrl_model
`default_nettype wire

/* File: motor_driver_spi_status_port_bench.sv */
// bench for the serial status port: table of frames, then hand tests
// assumes mdsp_ctrl_model as the far-side controller
`timescale 1ns/10ps
`default_nettype none
module motor_driver_spi_status_port_bench import mdsp_pkg::*;;
  // ********************
  // stimulus and wiring
  // ********************
  localparam int SLP = 40; // short sleep count keeps the run brief
  localparam logic WR = 1'h0;
  localparam logic RD = 1'h1;
  localparam logic OK = 1'h0;
  localparam logic BAD = 1'h1;
  localparam logic [4:0] F = 5'h10;
  typedef struct packed {
    logic rw; logic [5:0] a; logic [7:0] d; logic [4:0] n;
    logic bad; logic chk; logic [15:0] exp;
  } mdsp_row_s;
  logic clk_sys_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic sleep_n = 1'h1;
  logic vm_por = 1'h0;
  logic [7:0] bridge = 8'h00;
  logic [3:0] supply = 4'h0;
  logic [4:0] src = 5'h00; // buck, overcurrent, overvolt, shut, warn
  logic [15:0] rx;
  wire logic cs_n, sclk, sdi, sdo, sdo_oe, asleep, clr, sdo_line;
  wire logic [CTRL_N*8-1:0] ctrl;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int clr_seen = 0;
  int seen0;
  logic [7:0] sum_e [7] = '{8'h0B, 8'h0B, 8'h0D, 8'h19, 8'h49, 8'h09,
    8'h09};
  logic [7:0] dat_e [7] = '{8'h0B, 8'h0B, 8'h0D, 8'h19, 8'h49, 8'h5A,
    8'h48};
  mdsp_row_s rows [25] = '{
    '{WR, 6'h04, 8'hA5, F, OK, 1'h1, 16'h0000},
    '{RD, 6'h04, 8'h00, F, OK, 1'h1, 16'h00A5},
    '{WR, 6'h04, 8'h3C, F, OK, 1'h1, 16'h00A5},
    '{WR, 6'h0C, 8'h81, F, OK, 1'h1, 16'h0000},
    '{RD, 6'h0C, 8'h00, F, OK, 1'h1, 16'h0081},
    '{WR, 6'h00, 8'hFF, F, OK, 1'h1, 16'h0000},
    '{RD, 6'h00, 8'h00, F, OK, 1'h1, 16'h0000},
    '{WR, 6'h03, 8'h01, F, OK, 1'h1, 16'h0000},
    '{RD, 6'h03, 8'h00, F, OK, 1'h1, 16'h0800},
    '{WR, 6'h05, 8'h77, 5'h0C, OK, 1'h0, 16'h0000},
    '{RD, 6'h05, 8'h00, F, OK, 1'h1, 16'h2900},
    '{RD, 6'h02, 8'h00, F, OK, 1'h1, 16'h2902},
    '{WR, 6'h03, 8'h01, F, OK, 1'h1, 16'h2900},
    '{WR, 6'h05, 8'h77, 5'h11, OK, 1'h0, 16'h0000},
    '{RD, 6'h05, 8'h00, F, OK, 1'h1, 16'h2900},
    '{RD, 6'h02, 8'h00, F, OK, 1'h1, 16'h2902},
    '{WR, 6'h03, 8'h01, F, OK, 1'h1, 16'h2900},
    '{WR, 6'h05, 8'h66, F, BAD, 1'h1, 16'h0800},
    '{RD, 6'h02, 8'h00, F, OK, 1'h1, 16'h2904},
    '{RD, 6'h05, 8'h00, F, OK, 1'h1, 16'h2900},
    '{WR, 6'h03, 8'h01, F, OK, 1'h1, 16'h2900},
    '{RD, 6'h0D, 8'h00, F, OK, 1'h1, 16'h0800},
    '{RD, 6'h02, 8'h00, F, OK, 1'h1, 16'h2901},
    '{WR, 6'h03, 8'h01, F, OK, 1'h1, 16'h2900},
    '{RD, 6'h02, 8'h00, F, OK, 1'h1, 16'h0800}};
  // no pull on data-out: a released line shows the inverse of its level
  assign sdo_line = sdo_oe ? sdo : ~sdo;
  always #10 clk_sys_in = ~clk_sys_in;
  mdsp_port #(.SLEEP_CYCLES(SLP)) uut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .frame_select_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi),
    .sleep_control_n_in(sleep_n), .bridge_status_in(bridge),
    .supply_status_in(supply), .overcurrent_in(src[3]),
    .overvoltage_in(src[2]), .thermal_warn_in(src[0]),
    .thermal_shut_in(src[1]), .buck_fault_in(src[4]),
    .vm_por_in(vm_por), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .asleep_out(asleep), .clear_faults_out(clr), .ctrl_flat_out(ctrl));
  mdsp_ctrl_model mdl (.frame_select_n_out(cs_n), .sclk_out(sclk),
    .sdi_out(sdi), .sdo_line_in(sdo_line));
  // ********************
  // helpers
  // ********************
  // about 40 frames of 160 cycles each; the ceiling leaves ample slack
  // counted off the launching edge so the clear pulse has settled
  always @(negedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (clr === 1'h1) begin
      clr_seen <= clr_seen + 1;
    end
    if (cycles == 20000) begin
      fails = fails + 1;
      close_out();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [15:0] mk(input logic rw, input logic [5:0] a,
    input logic [7:0] d, input logic bad);
    logic [15:0] w;
    w = {rw, a, 1'h0, d};
    w[8] = (^w) ^ bad;
    return w;
  endfunction : mk
  task automatic frame(input logic rw, input logic [5:0] a,
    input logic [7:0] d, input logic [4:0] n, input logic bad);
    mdl.xfer(mk(rw, a, d, bad), int'(n), rx);
    check({15'h0000, sdo_oe}, 16'h0000);
  endtask : frame
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (20) @(negedge clk_sys_in);
    check({asleep, sdo_oe, clr, 13'h0000}, 16'h0000);
    check(ctrl[15:0], 16'h0000);
    rst_n_in = 1'h1;
    repeat (5) @(negedge clk_sys_in);
    $display("test reset done");
    foreach (rows[i]) begin
      frame(rows[i].rw, rows[i].a, rows[i].d, rows[i].n, rows[i].bad);
      if (rows[i].chk) begin
        check(rx, rows[i].exp);
      end
    end
    $display("test frame table done");
    // one fault source at a time, seen through the summary byte
    for (int i = 0; i < 7; i++) begin
      @(negedge clk_sys_in);
      src = (i < 5) ? (5'h01 << i) : 5'h00;
      bridge = (i == 5) ? 8'h5A : 8'h00;
      supply = (i == 6) ? 4'h9 : 4'h0;
      frame(RD, (i == 6) ? 6'h02 : (i == 5) ? 6'h01 : 6'h00, 8'h00, F, OK);
      check(rx, {sum_e[i], dat_e[i]});
    end
    @(negedge clk_sys_in);
    supply = 4'h0;
    vm_por = 1'h1;
    @(negedge clk_sys_in);
    vm_por = 1'h0;
    frame(RD, 6'h00, 8'h00, F, OK);
    check(rx, 16'h0000);
    $display("test summary bits done");
    // short sleep pulse clears the latched fault but keeps settings
    frame(WR, 6'h05, 8'h77, 5'h0C, OK);
    seen0 = clr_seen;
    @(negedge clk_sys_in);
    sleep_n = 1'h0;
    repeat (10) @(negedge clk_sys_in);
    sleep_n = 1'h1;
    repeat (10) @(negedge clk_sys_in);
    check(16'(clr_seen - seen0), 16'h0001);
    check({8'h00, ctrl[15:8]}, 16'h003C);
    frame(RD, 6'h02, 8'h00, F, OK);
    check(rx, 16'h0800);
    $display("test sleep pulse done");
    // long sleep: port disabled, registers back to defaults
    @(negedge clk_sys_in);
    sleep_n = 1'h0;
    repeat (SLP + 10) @(negedge clk_sys_in);
    check({15'h0000, asleep}, 16'h0001);
    frame(WR, 6'h04, 8'h11, F, OK);
    @(negedge clk_sys_in);
    sleep_n = 1'h1;
    repeat (10) @(negedge clk_sys_in);
    check({15'h0000, asleep}, 16'h0000);
    check({15'h0000, |ctrl}, 16'h0000);
    frame(RD, 6'h04, 8'h00, F, OK);
    check(rx, 16'h0000);
    $display("test long sleep done");
    // mid-run reset: registers back to defaults, no false frame after it
    frame(WR, 6'h04, 8'h5A, F, OK);
    check(rx, 16'h0000);
    check({8'h00, ctrl[15:8]}, 16'h005A);
    @(negedge clk_sys_in);
    rst_n_in = 1'h0;
    repeat (2) @(negedge clk_sys_in);
    check({8'h00, ctrl[15:8]}, 16'h0000);
    check({asleep, sdo_oe, clr, 13'h0000}, 16'h0000);
    rst_n_in = 1'h1;
    repeat (5) @(negedge clk_sys_in);
    check(16'(clr_seen - seen0), 16'h0001);
    frame(RD, 6'h02, 8'h00, F, OK);
    check(rx, 16'h0000);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : motor_driver_spi_status_port_bench
`default_nettype wire
